// ===== core/abkc_pkg.sv
// package for the air burst keystream cipher block
// assumes one 20 MHz clock domain and a classic wishbone register bus
package abkc_pkg;

  // ==========================================================
  // burst layout, positions within the 388-bit burst
  localparam int unsigned BURST_BITS    = 388;
  localparam int unsigned TAIL_FIRST    = 8;
  localparam int unsigned TAIL_END      = 48;   // first position after tail
  localparam int unsigned USER_FIRST    = 64;   // b0 of the user section
  localparam int unsigned USER_DATA_END = 384;  // first position of 4-bit crc
  localparam int unsigned SEG_BITS      = 360;
  localparam int unsigned SINGLE_DATA   = 304;
  localparam int unsigned SUB_PERIOD    = 80;   // 64 data + 16 crc
  localparam int unsigned SUB_DATA      = 64;

  // ==========================================================
  // payload protection formats
  localparam logic [1:0] FMT_UNPROT = 2'h0;
  localparam logic [1:0] FMT_MULTI  = 2'h1;
  localparam logic [1:0] FMT_SINGLE = 2'h2;

  // ==========================================================
  // mode control timing, in frames after the request frame
  localparam logic [3:0] CONFIRM_LAST = 4'hB;
  localparam logic [3:0] RX_IGN_FROM  = 4'h2;

  // ==========================================================
  // register map (byte offsets) and reset values
  localparam logic [7:0]  REG_CTRL    = 8'h00;
  localparam logic [7:0]  REG_STATUS  = 8'h04;
  localparam logic [7:0]  REG_KEY_LO  = 8'h08;
  localparam logic [7:0]  REG_KEY_HI  = 8'h0C;
  localparam logic [7:0]  REG_IV      = 8'h10;
  localparam logic [7:0]  REG_FRAMES  = 8'h14;
  localparam logic [31:0] CTRL_RESET  = 32'h0000_0000;
  localparam logic [31:0] KEY_RESET   = 32'h0000_0000;

  // ctrl and status field positions
  localparam int unsigned CTRL_ACCEPT  = 0;
  localparam int unsigned CTRL_HANDSET = 1;
  localparam int unsigned ST_RELEASE   = 4;
  localparam int unsigned ST_ORDER     = 5;

  // ==========================================================
  // state types
  typedef enum logic [2:0] {
    M_CLEAR   = 3'b001,
    M_CONFIRM = 3'b010,
    M_ENCRYPT = 3'b100
  } abkc_mode_e;

  typedef enum logic [2:0] {
    B_IDLE  = 3'b001,
    B_DRAIN = 3'b010,
    B_RUN   = 3'b100
  } abkc_burst_e;

endpackage : abkc_pkg

// ===== core/abkc_core.sv
// air burst keystream cipher: serial xor datapath and base-side mode control
// assumes bursts arrive bit by bit in air order, key bits from an outside
// generator, frame starts and received mode messages as one-cycle pulses
//
// Decided for this implementation: the address map and the Wishbone register port.
`timescale 1ns/100ps

// Summary of operation
// R1: a burst is 388 bits, 64 control bits then 324 user bits.
// R2: control is 8 header, 40 tail, 16 crc; header tells tail type.
// R3: user section is 320 data bits then a 4-bit crc.
// R4: unprotected format: all 320 user data bits carry data.
// R5: multi format: four 64-bit subfields, each with its own 16-bit crc.
// R6: single format: one 304-bit subfield with one 16-bit crc.
// R7: header and all crcs stay clear; tail ciphered only if signalling.
// R8: each ciphered burst uses a 360-bit segment, index 0 first.
// R9: key 0..39 xor tail bits 8..47 if signalling, else discarded.
// R10: unprotected: key 40..359 xor user bits 0..319.
// R11: single: key 40..343 xor user bits 0..303, rest unused.
// R12: multi: four 64-bit key windows xor the four subfields.
// R13: decipher uses the same xor mapping as cipher.
// R14: crcs are made and checked over ciphered bits, outside this block.
// R15: connection starts clear; switching happens at agreed frames.
// R16: generator gets the same 64-bit key, bit 0 least significant.
// R17: init vector: frame number bits 0-3, multiframe 4-27, zero above.
// R18: generator re-initialised each encrypted frame, yields two segments.
// R19: base ciphers tx with first segment; handset the reverse.
// R20: mode messages travel clear; base sends only in odd frames.
// R21: handset starts switching; the mode applies to every bearer.
// R22: base repeats confirm each odd frame until grant or timeout.
// R23: handset gives up after five unanswered requests.
// R24: base enters encrypt at once, confirms until frame 2S+11, else release.
// R25: handset treats confirm burst as ciphered, ciphers from grant on.
// R26: base uses deciphered rx from grant frame, ignores earlier rx.
// R27: key bits arrive serially from an outside generator, used in order.
module abkc_core
  import abkc_pkg::*;
(
  input  wire logic        MCLK_IN,
  input  wire logic        RST_IN,
  // wishbone slave
  input  wire logic        WB_CYC_IN,
  input  wire logic        WB_STB_IN,
  input  wire logic        WB_WE_IN,
  input  wire logic [7:0]  WB_ADR_IN,
  input  wire logic [3:0]  WB_SEL_IN,
  input  wire logic [31:0] WB_DAT_IN,
  output logic      [31:0] WB_DAT_OUT,
  output logic             WB_ACK_OUT,
  // frame timing
  input  wire logic        FRAME_START_IN,
  input  wire logic [3:0]  FRAME_NUM_IN,
  input  wire logic [23:0] MFRAME_NUM_IN,
  // received mode messages
  input  wire logic        START_REQ_RX_IN,
  input  wire logic        GRANT_RX_IN,
  // burst stream
  input  wire logic        BURST_START_IN,
  input  wire logic        BURST_RX_IN,
  input  wire logic        TAIL_SIG_IN,
  input  wire logic [1:0]  FMT_IN,
  input  wire logic        BIT_VALID_IN,
  input  wire logic        BIT_IN,
  output logic             BIT_READY_OUT,
  output logic             CIPH_VALID_OUT,
  output logic             CIPH_BIT_OUT,
  // keystream generator
  output logic             KSG_INIT_OUT,
  output logic      [63:0] KSG_KEY_OUT,
  output logic      [34:0] KSG_IV_OUT,
  input  wire logic        KS_VALID_IN,
  input  wire logic        KS_BIT_IN,
  output logic             KS_READY_OUT,
  // mode control outputs
  output logic             MODE_ENCRYPT_OUT,
  output logic             SEND_CONFIRM_OUT,
  output logic             RX_IGNORE_OUT,
  output logic             RELEASE_OUT
);

  // ==========================================================
  // declarations
  logic        ack_r;
  logic [31:0] rdat_r;
  logic [31:0] ctrl_r;
  logic [31:0] key_lo_r;
  logic [31:0] key_hi_r;
  logic        wr_hit;
  logic        release_st_r;
  logic        order_st_r;
  logic        rel_clr;
  logic        ord_clr;
  abkc_mode_e  mode_r;
  logic [3:0]  frames_r;
  logic        release_r;
  logic [3:0]  fnum_r;
  logic [23:0] mfn_r;
  logic        init_r;
  logic [1:0]  seg_next_r;
  abkc_burst_e bst_r;
  logic [8:0]  pos_r;
  logic [8:0]  drain_r;
  logic        b_tail_r;
  logic [1:0]  b_fmt_r;
  logic        b_ciph_r;
  logic        handset;
  logic        tx_ciph;
  logic        rx_ciph;
  logic        want_ciph;
  logic        need_seg;
  logic        in_tail;
  logic        in_user;
  logic [8:0]  user_idx;
  logic        need_key;
  logic        xor_here;
  logic        take_bit;
  logic        ciph_out_r;
  logic        ciph_vld_r;

  assign handset = ctrl_r[CTRL_HANDSET];

  // byte-lane merge for wishbone writes
  function automatic logic [31:0] merge(input logic [31:0] old_v,
                                        input logic [31:0] new_v,
                                        input logic [3:0]  sel);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        res[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return res;
  endfunction : merge

  // ==========================================================
  // wishbone slave: ack one cycle after request, dropped after one cycle
  always_ff @(posedge MCLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= WB_CYC_IN & WB_STB_IN & ~ack_r;
    end
  end

  // writes land on the edge at which the master samples ack
  assign wr_hit = ack_r & WB_CYC_IN & WB_STB_IN & WB_WE_IN;

  always_ff @(posedge MCLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      ctrl_r   <= CTRL_RESET;
      key_lo_r <= KEY_RESET;
      key_hi_r <= KEY_RESET;
    end else if (wr_hit) begin
      unique case (WB_ADR_IN)
        REG_CTRL:   ctrl_r   <= merge(ctrl_r, WB_DAT_IN, WB_SEL_IN) &
                                32'h0000_0003;
        REG_KEY_LO: key_lo_r <= merge(key_lo_r, WB_DAT_IN, WB_SEL_IN);
        REG_KEY_HI: key_hi_r <= merge(key_hi_r, WB_DAT_IN, WB_SEL_IN);
        default: ;
      endcase
    end
  end

  // read data captured with ack; unmapped offsets read zero
  always_ff @(posedge MCLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      rdat_r <= 32'h0000_0000;
    end else if (WB_CYC_IN & WB_STB_IN & ~ack_r) begin
      unique case (WB_ADR_IN)
        REG_CTRL:   rdat_r <= ctrl_r;
        REG_STATUS: rdat_r <= {26'h0, order_st_r, release_st_r,
                               RX_IGNORE_OUT, mode_r};
        REG_KEY_LO: rdat_r <= key_lo_r;
        REG_KEY_HI: rdat_r <= key_hi_r;
        REG_IV:     rdat_r <= KSG_IV_OUT[31:0];
        REG_FRAMES: rdat_r <= {28'h0, frames_r};
        default:    rdat_r <= 32'h0000_0000;
      endcase
    end
  end

  assign WB_ACK_OUT = ack_r;
  assign WB_DAT_OUT = rdat_r;

  // sticky status, write one to clear; a new event beats the clear
  assign rel_clr = wr_hit && WB_ADR_IN == REG_STATUS && WB_SEL_IN[0] &&
                   WB_DAT_IN[ST_RELEASE];
  assign ord_clr = wr_hit && WB_ADR_IN == REG_STATUS && WB_SEL_IN[0] &&
                   WB_DAT_IN[ST_ORDER];

  always_ff @(posedge MCLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      release_st_r <= 1'b0;
      order_st_r   <= 1'b0;
    end else begin
      release_st_r <= release_r | (release_st_r & ~rel_clr);
      order_st_r   <= (BURST_START_IN && bst_r == B_IDLE && want_ciph &&
                       seg_next_r > {1'b0, need_seg}) |
                      (order_st_r & ~ord_clr);
    end
  end

  // ==========================================================
  // mode control, base end of the switch to encrypt
  // the handset end is driven by software outside; here it only stays clear
  always_ff @(posedge MCLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      mode_r    <= M_CLEAR;                                   // R15
      frames_r  <= 4'h0;
      release_r <= 1'b0;
    end else begin
      release_r <= 1'b0;
      unique case (mode_r)
        M_CLEAR: begin
          // only a received request moves us: the handset initiates
          if (START_REQ_RX_IN && ctrl_r[CTRL_ACCEPT] && !handset) begin
            mode_r   <= M_CONFIRM;                            // R21 R24
            frames_r <= 4'h0;
          end
        end
        M_CONFIRM: begin
          if (GRANT_RX_IN) begin
            mode_r <= M_ENCRYPT;                              // R26
          end else if (FRAME_START_IN) begin
            if (frames_r == CONFIRM_LAST) begin
              mode_r    <= M_CLEAR;                           // R24
              release_r <= 1'b1;
            end else begin
              frames_r <= frames_r + 4'h1;
            end
          end
        end
        M_ENCRYPT: begin
          // leaving encrypt mode is handled by a later connection reset
          mode_r <= M_ENCRYPT;
        end
      endcase
    end
  end

  // tx ciphered from the cycle after the request on; rx clear in 2S+1
  assign tx_ciph = mode_r != M_CLEAR;                         // R24
  assign rx_ciph = mode_r == M_ENCRYPT ||
                   (mode_r == M_CONFIRM && frames_r >= RX_IGN_FROM);

  assign MODE_ENCRYPT_OUT = tx_ciph;                          // R21
  // confirm only in odd frames, message itself never ciphered
  assign SEND_CONFIRM_OUT = mode_r == M_CONFIRM && fnum_r[0]; // R20 R22
  assign RX_IGNORE_OUT    = mode_r == M_CONFIRM &&
                            frames_r >= RX_IGN_FROM;          // R26
  assign RELEASE_OUT      = release_r;

  // ==========================================================
  // per-frame generator load
  always_ff @(posedge MCLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      fnum_r <= 4'h0;
      mfn_r  <= 24'h00_0000;
      init_r <= 1'b0;
    end else begin
      init_r <= FRAME_START_IN & tx_ciph;                     // R18
      if (FRAME_START_IN) begin
        fnum_r <= FRAME_NUM_IN;
        mfn_r  <= MFRAME_NUM_IN;
      end
    end
  end

  assign KSG_INIT_OUT = init_r;
  assign KSG_KEY_OUT  = {key_hi_r, key_lo_r};                 // R16
  assign KSG_IV_OUT   = {7'h00, mfn_r, fnum_r};               // R17

  // ==========================================================
  // burst sequencing
  // base: tx uses segment 0, rx segment 1; handset swapped
  assign need_seg  = BURST_RX_IN ^ handset;                   // R19
  assign want_ciph = BURST_RX_IN ? rx_ciph : tx_ciph;

  assign in_tail  = pos_r >= 9'(TAIL_FIRST) && pos_r < 9'(TAIL_END);
  assign in_user  = pos_r >= 9'(USER_FIRST) && pos_r < 9'(USER_DATA_END);
  assign user_idx = pos_r - 9'(USER_FIRST);

  // key bit index equals position minus offset, so every format uses one
  // bit per tail or user-data position and unused bits simply drop
  assign need_key = b_ciph_r && (in_tail || in_user);         // R8 R27

  always_comb begin
    xor_here = 1'b0;
    if (in_tail) begin
      xor_here = b_tail_r;                                    // R7 R9
    end else if (in_user) begin
      unique case (b_fmt_r)
        FMT_UNPROT: xor_here = 1'b1;                          // R4 R10
        FMT_SINGLE: xor_here = user_idx < 9'(SINGLE_DATA);    // R6 R11
        FMT_MULTI:  xor_here = user_idx < 9'(SINGLE_DATA) &&
                               (user_idx % 9'(SUB_PERIOD)) <
                               9'(SUB_DATA);                  // R5 R12
        default:    xor_here = 1'b0;
      endcase
    end
  end

  // stall the burst source while a needed key bit is missing
  assign BIT_READY_OUT = bst_r == B_RUN && (!need_key || KS_VALID_IN);
  assign take_bit      = BIT_READY_OUT && BIT_VALID_IN;
  assign KS_READY_OUT  = bst_r == B_DRAIN ||
                         (bst_r == B_RUN && need_key && BIT_VALID_IN);

  always_ff @(posedge MCLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      bst_r      <= B_IDLE;
      pos_r      <= 9'h000;
      drain_r    <= 9'h000;
      b_tail_r   <= 1'b0;
      b_fmt_r    <= FMT_UNPROT;
      b_ciph_r   <= 1'b0;
      seg_next_r <= 2'h2;
    end else begin
      if (init_r) begin
        seg_next_r <= 2'h0;
      end
      unique case (bst_r)
        B_IDLE: begin
          if (BURST_START_IN) begin
            b_tail_r <= TAIL_SIG_IN;
            b_fmt_r  <= FMT_IN;
            pos_r    <= 9'h000;
            // a segment already spent cannot be replayed: pass clear
            b_ciph_r <= want_ciph && seg_next_r <= {1'b0, need_seg};
            if (want_ciph && seg_next_r == 2'h0 && need_seg) begin
              bst_r   <= B_DRAIN;      // skip the other side's segment
              drain_r <= 9'h000;
            end else begin
              bst_r <= B_RUN;
            end
          end
        end
        B_DRAIN: begin
          if (KS_VALID_IN) begin
            if (drain_r == 9'(SEG_BITS - 1)) begin
              bst_r      <= B_RUN;
              seg_next_r <= 2'h1;
            end else begin
              drain_r <= drain_r + 9'h001;
            end
          end
        end
        B_RUN: begin
          if (take_bit) begin
            if (pos_r == 9'(BURST_BITS - 1)) begin             // R1
              bst_r <= B_IDLE;
              if (b_ciph_r) begin
                seg_next_r <= seg_next_r + 2'h1;
              end
            end else begin
              pos_r <= pos_r + 9'h001;
            end
          end
        end
      endcase
    end
  end

  // ==========================================================
  // xor stage: same path for both directions; crcs are formed outside
  // on the ciphered stream, so header and crc positions pass untouched
  always_ff @(posedge MCLK_IN or posedge RST_IN) begin
    if (RST_IN) begin
      ciph_out_r <= 1'b0;
      ciph_vld_r <= 1'b0;
    end else begin
      ciph_vld_r <= take_bit;
      if (take_bit) begin
        ciph_out_r <= BIT_IN ^ (need_key & xor_here & KS_BIT_IN); // R13 R14
      end
    end
  end

  // positions 0-7 header, 48-63 control crc, 384-387 user crc stay clear
  // (R2 R3) because neither in_tail nor in_user covers them
  assign CIPH_VALID_OUT = ciph_vld_r;
  assign CIPH_BIT_OUT   = ciph_out_r;

endmodule : abkc_core

// ===== bench/abkc_props.sv
// checker: port-level timing of the air burst cipher block
// assumes it is bound into abkc_core, one clock, async active-high reset
`timescale 1ns/100ps
module abkc_props (
  input wire logic        MCLK_IN, RST_IN, WB_CYC_IN, WB_STB_IN,
  input wire logic        WB_ACK_OUT, BIT_VALID_IN, BIT_IN, BIT_READY_OUT,
  input wire logic        CIPH_VALID_OUT, CIPH_BIT_OUT, KS_VALID_IN,
  input wire logic        KS_READY_OUT, FRAME_START_IN, START_REQ_RX_IN,
  input wire logic        KSG_INIT_OUT, MODE_ENCRYPT_OUT, RELEASE_OUT,
  input wire logic [3:0]  FRAME_NUM_IN,
  input wire logic [23:0] MFRAME_NUM_IN,
  input wire logic [34:0] KSG_IV_OUT
);
  logic taken;

  // a burst bit moves on an edge with valid and ready both high
  assign taken = BIT_VALID_IN && BIT_READY_OUT;

  default clocking cb @(posedge MCLK_IN); endclocking
  default disable iff (RST_IN);

  // ==========================================================
  // bus answer, result timing, mode control
  a_ack_single: assert property (
    WB_CYC_IN && WB_STB_IN && !WB_ACK_OUT |=> WB_ACK_OUT ##1 !WB_ACK_OUT)
    else $error("ack not one pulse one cycle after request");
  a_ack_cause: assert property (
    $rose(WB_ACK_OUT) |-> $past(WB_CYC_IN && WB_STB_IN))
    else $error("ack without a request");
  a_result_timing: assert property (
    1'b1 |=> CIPH_VALID_OUT == $past(taken))
    else $error("result valid not one edge after a taken bit");
  a_clear_passthru: assert property (
    taken && !MODE_ENCRYPT_OUT |=> CIPH_BIT_OUT == $past(BIT_IN))
    else $error("bit altered in clear mode");
  a_key_with_bit: assert property (
    taken && KS_READY_OUT |-> KS_VALID_IN)
    else $error("bit taken while its key bit was missing");
  a_mode_cause: assert property (
    $rose(MODE_ENCRYPT_OUT) |-> $past(START_REQ_RX_IN))
    else $error("mode left clear without a request");
  a_init_cause: assert property (
    KSG_INIT_OUT |-> $past(FRAME_START_IN) && $past(MODE_ENCRYPT_OUT))
    else $error("generator load without frame start in cipher mode");
  a_iv_fields: assert property (
    KSG_INIT_OUT |->
      KSG_IV_OUT == {7'h00, $past(MFRAME_NUM_IN), $past(FRAME_NUM_IN)})
    else $error("init vector fields wrong");
  a_release_form: assert property (
    RELEASE_OUT |=> !RELEASE_OUT && !MODE_ENCRYPT_OUT)
    else $error("release not a pulse or mode not cleared");
endmodule : abkc_props

bind abkc_core abkc_props abkc_props_i (
  .MCLK_IN, .RST_IN, .WB_CYC_IN, .WB_STB_IN, .WB_ACK_OUT, .BIT_VALID_IN,
  .BIT_IN, .BIT_READY_OUT, .CIPH_VALID_OUT, .CIPH_BIT_OUT, .KS_VALID_IN,
  .KS_READY_OUT, .FRAME_START_IN, .START_REQ_RX_IN, .KSG_INIT_OUT,
  .MODE_ENCRYPT_OUT, .RELEASE_OUT, .FRAME_NUM_IN, .MFRAME_NUM_IN,
  .KSG_IV_OUT);

// ===== bench/abkc_ksg_model.sv
// key stream generator model and the key bit pattern it yields
// assumes a load pulse with key and vector from the block, one clock
`timescale 1ns/100ps
package abkc_tb_pkg;
  // pattern mixes key and vector so a wrong load shows in the data
  function automatic logic ks_bit(int i, logic [63:0] k, logic [34:0] v);
    return k[i % 64] ^ v[i % 35] ^ i[0] ^ i[3];
  endfunction : ks_bit
endpackage : abkc_tb_pkg

module abkc_ksg_model
  import abkc_tb_pkg::*;
(
  input  wire logic        clk_in,
  input  wire logic        rst_in,
  input  wire logic        init_in,
  input  wire logic [63:0] key_in,
  input  wire logic [34:0] iv_in,
  input  wire logic        slow_in,
  input  wire logic        ready_in,
  output logic             valid_out,
  output logic             bit_out
);
  logic [9:0]  idx_r;
  logic [63:0] key_r;
  logic [34:0] iv_r;
  logic        ks;

  // ==========================================================
  // reload on each load pulse, then 720 bits in order, index 0 first
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      idx_r     <= 10'h2D0;
      key_r     <= 64'h0;
      iv_r      <= 35'h0;
      valid_out <= 1'b0;
    end else if (init_in) begin
      idx_r     <= 10'h000;
      key_r     <= key_in;
      iv_r      <= iv_in;
      valid_out <= !slow_in;
    end else if (valid_out && ready_in) begin
      idx_r     <= idx_r + 10'h001;
      // slow: one idle cycle after each bit stresses the stall path
      valid_out <= !slow_in && idx_r < 10'h2CF;
    end else if (!valid_out && idx_r < 10'h2D0) begin
      valid_out <= 1'b1;
    end
  end

  // off the handshake the line shows the opposite, never a stale bit
  assign ks      = ks_bit(int'(idx_r), key_r, iv_r);
  assign bit_out = valid_out ? ks : !ks;
endmodule : abkc_ksg_model

// ===== bench/air_burst_keystream_cipher_bench.sv
// testbench: base-side burst cipher with a key stream model
// assumes abkc_pkg, abkc_core, abkc_ksg_model, abkc_props compiled first
`timescale 1ns/100ps
module air_burst_keystream_cipher_bench;
  import abkc_pkg::*;
  import abkc_tb_pkg::*;
  logic        clk, rst, cyc, stb, we, fs, req, grant, bst, brx, sig;
  logic        bv, bi, slow;
  logic [3:0]  sel, fn;
  logic [7:0]  adr;
  logic [31:0] wdat, q;
  logic [23:0] mf;
  logic [1:0]  fmt;
  logic [63:0] key;
  logic [34:0] iv;
  int          err_total, total_checks;
  wire         ack, rdy, cv, cb, init, ksv, ksb, ksr, menc, conf, ign, rel;
  wire  [31:0] rdat;
  wire  [63:0] kkey;
  wire  [34:0] kiv;

  abkc_core abkc_core_i (
    .MCLK_IN(clk), .RST_IN(rst), .WB_CYC_IN(cyc), .WB_STB_IN(stb),
    .WB_WE_IN(we), .WB_ADR_IN(adr), .WB_SEL_IN(sel), .WB_DAT_IN(wdat),
    .WB_DAT_OUT(rdat), .WB_ACK_OUT(ack), .FRAME_START_IN(fs),
    .FRAME_NUM_IN(fn), .MFRAME_NUM_IN(mf), .START_REQ_RX_IN(req),
    .GRANT_RX_IN(grant), .BURST_START_IN(bst), .BURST_RX_IN(brx),
    .TAIL_SIG_IN(sig), .FMT_IN(fmt), .BIT_VALID_IN(bv), .BIT_IN(bi),
    .BIT_READY_OUT(rdy), .CIPH_VALID_OUT(cv), .CIPH_BIT_OUT(cb),
    .KSG_INIT_OUT(init), .KSG_KEY_OUT(kkey), .KSG_IV_OUT(kiv),
    .KS_VALID_IN(ksv), .KS_BIT_IN(ksb), .KS_READY_OUT(ksr),
    .MODE_ENCRYPT_OUT(menc), .SEND_CONFIRM_OUT(conf),
    .RX_IGNORE_OUT(ign), .RELEASE_OUT(rel));
  abkc_ksg_model abkc_ksg_model_i (
    .clk_in(clk), .rst_in(rst), .init_in(init), .key_in(kkey),
    .iv_in(kiv), .slow_in(slow), .ready_in(ksr), .valid_out(ksv),
    .bit_out(ksb));

  // ==========================================================
  // clock, helpers and scenarios
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic chk(string nm, logic [63:0] e, logic [63:0] g);
    total_checks++;
    if (g !== e) begin
      err_total++;
      $display("ERROR %s expected %h seen %h", nm, e, g);
    end
  endtask : chk

  // classic cycle: hold everything until ack is seen at an edge
  task automatic wb(logic w, logic [7:0] a, logic [31:0] d, logic [3:0] s);
    int n;
    @(posedge clk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    sel <= s;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 40);
    q = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
    if (n >= 40) chk("wb ack", 64'h1, 64'h0);
  endtask : wb

  task automatic frame(logic [3:0] n);
    @(posedge clk);
    fs <= 1'b1;
    fn <= n;
    iv = {7'h00, mf, n};
    @(posedge clk);
    fs <= 1'b0;
    repeat (3) @(posedge clk);
  endtask : frame

  function automatic logic din(int p);
    return p[0] ^ p[2] ^ p[5];
  endfunction : din

  // expected air bit at position p for one burst setting
  function automatic logic expb(int p, logic s, logic [1:0] f, int g,
                                logic ci);
    int  b;
    logic u;
    b = p - 64;
    if (p >= 8 && p < 48) return din(p) ^ (ci & s & ks_bit(g+p-8, key, iv));
    if (p < 64 || p >= 384) return din(p);
    u = f == FMT_UNPROT || (b < 304 && (f == FMT_SINGLE || b % 80 < 64));
    return din(p) ^ (ci & u & ks_bit(g + b + 40, key, iv));
  endfunction : expb

  task automatic burst(logic rx, logic s, logic [1:0] f, int g, logic ci);
    int   p, n;
    logic tk, pend;
    @(posedge clk);
    bst <= 1'b1;
    brx <= rx;
    sig <= s;
    fmt <= f;
    @(posedge clk);
    bst <= 1'b0;
    bv <= 1'b1;
    bi <= din(0);
    p = 0;
    n = 0;
    pend = 1'b0;
    while ((p < 388 || pend) && n < 2000) begin
      @(negedge clk);
      if (pend) chk("air bit", {1'b1, expb(p-1, s, f, g, ci)}, {cv, cb});
      tk = bv && rdy;
      @(posedge clk);
      n++;
      pend = tk;
      if (tk) begin
        p++;
        bi <= din(p);
        bv <= (p < 388);
      end
    end
    if (n >= 2000) chk("burst length", 64'd388, 64'(p));
  endtask : burst

  task automatic t_regs;
    wb(1'b0, REG_STATUS, 32'h0, 4'hF);
    chk("status reset", 64'h1, 64'(q));
    wb(1'b0, REG_KEY_LO, 32'h0, 4'hF);
    chk("key reset", 64'(KEY_RESET), 64'(q));
    key = 64'h0123_4567_89AB_CDEF;
    wb(1'b1, REG_KEY_LO, key[31:0], 4'hF);
    wb(1'b1, REG_KEY_HI, key[63:32], 4'hF);
    wb(1'b1, REG_KEY_LO, 32'hFFFF_FFFF, 4'h2);
    key[15:8] = 8'hFF;
    wb(1'b0, REG_KEY_LO, 32'h0, 4'hF);
    chk("key lane", 64'(key[31:0]), 64'(q));
    chk("key to generator", key, kkey);
    wb(1'b0, 8'h40, 32'h0, 4'hF);
    chk("unmapped read", 64'h0, 64'(q));
    wb(1'b1, REG_CTRL, 32'h1, 4'hF);
  endtask : t_regs

  task automatic t_clear;
    burst(1'b0, 1'b1, FMT_UNPROT, 0, 1'b0);
  endtask : t_clear

  task automatic t_start;
    mf <= 24'h5A3C96;
    frame(4'h2);
    req <= 1'b1;
    @(posedge clk);
    req <= 1'b0;
    @(negedge clk);
    chk("mode after request", 64'h1, 64'(menc));
    frame(4'h3);
    chk("confirm odd frame", 64'h1, 64'(conf));
    frame(4'h4);
    chk("confirm even frame", 64'h0, 64'(conf));
    chk("rx ignored", 64'h1, 64'(ign));
    wb(1'b0, REG_FRAMES, 32'h0, 4'hF);
    chk("frame count", 64'h2, 64'(q));
    grant <= 1'b1;
    @(posedge clk);
    grant <= 1'b0;
    @(negedge clk);
    chk("rx used after grant", 64'h0, 64'(ign));
  endtask : t_start

  // tx uses segment 0, rx segment 1, every format and tail kind
  task automatic t_cipher;
    for (int i = 0; i < 4; i++) begin
      slow <= (i == 1);
      frame(4'(5 + i));
      burst(1'b0, i != 1, 2'(i == 3 ? 1 : i), 0, 1'b1);
      burst(1'b1, 1'b1, 2'(i == 3 ? 1 : i), 360, 1'b1);
    end
    // rx before tx: the first segment is drained, a late tx goes clear
    frame(4'h9);
    burst(1'b1, 1'b0, FMT_SINGLE, 360, 1'b1);
    burst(1'b0, 1'b1, FMT_UNPROT, 0, 1'b0);
    wb(1'b0, REG_STATUS, 32'h0, 4'hF);
    chk("order error", 64'h24, 64'(q & 32'h3F));
    wb(1'b0, REG_IV, 32'h0, 4'hF);
    chk("iv read", 64'(iv[31:0]), 64'(q));
  endtask : t_cipher

  task automatic t_timeout;
    @(posedge clk);
    rst <= 1'b1;
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    wb(1'b1, REG_CTRL, 32'h1, 4'hF);
    frame(4'h2);
    req <= 1'b1;
    @(posedge clk);
    req <= 1'b0;
    for (int j = 1; j <= 11; j++) frame(4'(2 + j));
    chk("mode at last confirm", 64'h1, 64'(menc));
    frame(4'hE);
    chk("mode after timeout", 64'h0, 64'(menc));
    wb(1'b0, REG_STATUS, 32'h0, 4'hF);
    chk("status release", 64'h11, 64'(q & 32'h17));
    wb(1'b1, REG_STATUS, 32'h10, 4'hF);
    wb(1'b0, REG_STATUS, 32'h0, 4'hF);
    chk("release cleared", 64'h0, 64'(q[4]));
  endtask : t_timeout

  task automatic end_sim;
    $display("checks %0d errors %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : end_sim

  initial begin
    {rst, cyc, stb, we, fs, req, grant, bst, brx, sig, bv, bi, slow} = '0;
    rst = 1'b1;
    {sel, fn, adr, wdat, mf, fmt} = '0;
    key = 64'h0;
    iv = 35'h0;
    repeat (10) @(posedge clk);
    rst <= 1'b0;
    t_regs;
    t_clear;
    t_start;
    t_cipher;
    t_timeout;
    end_sim;
  end

  // hang guard, well above the roughly 5600 cycles the tests need
  initial begin
    repeat (30000) @(posedge clk);
    err_total++;
    end_sim;
  end
endmodule : air_burst_keystream_cipher_bench
